// *** include/rrs_pkg.sv ***
// package for reset release and test strap sampler
// Behaviour
// - self-configuration starts when a rising edge on power_on_reset_n is detected.
// - every output stays inactive while power_on_reset_n is low.
// - test strap pins are undriven, with only weak pulldowns, while reset is low.
// - about 1.5 us after release the straps are sampled as test mode, then driven.
// - a high strap at sampling may select a test mode; the board avoids pullups there.
// - after sampling, strap pin four drives trigger_output_one.
// - the other strap pins, once driven, carry only reserved test outputs.
package rrs_pkg;
    localparam int unsigned RRS_CLK_MHZ = 200;
    localparam int unsigned RRS_SAMPLE_NS = 1500;
    localparam int unsigned RRS_SAMPLE_CYC = (RRS_SAMPLE_NS * RRS_CLK_MHZ + 999) / 1000;
    localparam int unsigned RRS_STRAP_W = 8;
    localparam int unsigned RRS_TRIG_BIT = 4;
    localparam int unsigned RRS_CNT_W = 12;

    typedef enum logic [3:0] {
        RRS_HELD = 4'h1,
        RRS_WAIT = 4'h2,
        RRS_SAMPLE = 4'h4,
        RRS_RUN = 4'h8
    } rrs_state_e;

    typedef struct packed {
        logic [RRS_STRAP_W-1:0] out;
        logic [RRS_STRAP_W-1:0] oe;
    } rrs_strap_drive_s;
endpackage

// *** design/rrs_reset_sync.sv ***
// reset release synchroniser, three flops
`timescale 1ns/1ps
module rrs_reset_sync
    import rrs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic power_on_reset_n,
    output logic released
);
    logic [2:0] sync_q;
    always_ff @(posedge sys_clk or negedge arst_n or negedge power_on_reset_n) begin
        if (!arst_n || !power_on_reset_n) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], 1'b1};
        end
    end
    // second and third both high
    assign released = sync_q[1] & sync_q[2];
endmodule

// *** design/rrs_strap_sampler.sv ***
// reset release and test strap sampler top
`timescale 1ns/1ps
module rrs_strap_sampler
    import rrs_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = RRS_SAMPLE_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic power_on_reset_n,
    input wire logic scan_port_reset_n,
    input wire logic [RRS_STRAP_W-1:0] test_strap_pins_i,
    output logic [RRS_STRAP_W-1:0] test_strap_pins_o,
    output logic [RRS_STRAP_W-1:0] test_strap_pins_oe,
    input wire logic trigger_output_one,
    input wire logic [RRS_STRAP_W-1:0] test_out_data,
    output logic config_start,
    output logic config_active,
    output logic [RRS_STRAP_W-1:0] test_mode_sel
);
    logic released;
    logic [RRS_STRAP_W-1:0] s1_q, s2_q, s3_q;
    logic [RRS_CNT_W-1:0] cnt_q;
    rrs_state_e state_q, state_d;
    logic rel_q;
    logic start_q;
    logic [RRS_STRAP_W-1:0] mode_q;
    rrs_strap_drive_s drv_q, drv_d;
    wire logic held_n = arst_n & power_on_reset_n;
    wire logic cnt_done = (cnt_q == RRS_CNT_W'(SAMPLE_CYC - 1));
    wire logic [RRS_STRAP_W-1:0] strap_stable = s2_q;
    wire logic in_wait = (state_q == RRS_WAIT);
    wire logic in_sample = (state_q == RRS_SAMPLE);
    wire logic in_run = (state_q == RRS_RUN);
    wire logic next_run = (state_d == RRS_RUN);
    wire logic strap_agree = (s2_q == s3_q);
    localparam logic [RRS_STRAP_W-1:0] TRIG_MASK = {{(RRS_STRAP_W-1){1'b0}}, 1'b1} << RRS_TRIG_BIT;

    rrs_reset_sync u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .power_on_reset_n(power_on_reset_n),
        .released(released)
    );

    // strap input synchroniser
    always_ff @(posedge sys_clk or negedge held_n) begin
        if (!held_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= test_strap_pins_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            RRS_HELD: begin
                if (released) begin
                    state_d = RRS_WAIT;
                end
            end
            RRS_WAIT: begin
                if (cnt_done) begin
                    state_d = RRS_SAMPLE;
                end
            end
            RRS_SAMPLE: state_d = RRS_RUN;
            RRS_RUN: state_d = RRS_RUN;
            default: state_d = RRS_HELD;
        endcase
    end

    // pin drive image for one state
    function automatic rrs_strap_drive_s strap_image(
        input logic [RRS_STRAP_W-1:0] data,
        input logic trig,
        input logic drive
    );
        rrs_strap_drive_s img;
        img.out = data;
        img.out[RRS_TRIG_BIT] = trig;
        img.oe = drive ? '1 : '0;
        if (!drive) begin
            img.out = '0;
        end
        return img;
    endfunction

    // pin four carries trigger, rest reserved test outputs
    assign drv_d = strap_image(test_out_data, trigger_output_one, next_run);

    // all inactive and undriven while held
    always_ff @(posedge sys_clk or negedge held_n) begin
        if (!held_n) begin
            state_q <= RRS_HELD;
            cnt_q <= '0;
            rel_q <= 1'b0;
            start_q <= 1'b0;
            mode_q <= '0;
            drv_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_q == RRS_WAIT) ? cnt_q + 1'b1 : '0;
            rel_q <= released;
            start_q <= released & ~rel_q;
            drv_q <= drv_d;
            if (state_q == RRS_SAMPLE && s2_q == s3_q) begin
                mode_q <= strap_stable;
            end
        end
    end

    assign test_strap_pins_o = drv_q.out;
    assign test_strap_pins_oe = drv_q.oe;
    assign config_start = start_q;
    assign config_active = rel_q;
    assign test_mode_sel = mode_q;

    property p_held_quiet;
        @(posedge sys_clk) !power_on_reset_n |-> (test_strap_pins_oe == '0 && test_strap_pins_o == '0
            && !config_start && !config_active && test_mode_sel == '0);
    endproperty
    a_held_quiet: assert property (p_held_quiet) else $error("outputs active during reset");

    property p_tristate;
        @(posedge sys_clk) disable iff (!arst_n) !power_on_reset_n |-> test_strap_pins_oe == '0;
    endproperty
    a_tristate: assert property (p_tristate) else $error("straps driven in reset");

    property p_start;
        @(posedge sys_clk) disable iff (!held_n) $rose(released) |=> config_start ##1 !config_start;
    endproperty
    a_start: assert property (p_start) else $error("config start missing");

    property p_sample_time;
        @(posedge sys_clk) disable iff (!held_n) $rose(state_q == RRS_WAIT) |-> ##SAMPLE_CYC (state_q == RRS_SAMPLE);
    endproperty
    a_sample_time: assert property (p_sample_time) else $error("sampling time wrong");

    property p_drive_after;
        @(posedge sys_clk) disable iff (!held_n) (state_q == RRS_SAMPLE) |=> test_strap_pins_oe == '1;
    endproperty
    a_drive_after: assert property (p_drive_after) else $error("straps not driven");

    property p_trig;
        @(posedge sys_clk) disable iff (!held_n)
            (state_q == RRS_RUN && $past(state_q) == RRS_RUN)
            |-> test_strap_pins_o[RRS_TRIG_BIT] == $past(trigger_output_one);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger not on pin four");

    property p_reserved;
        @(posedge sys_clk) disable iff (!held_n) (state_q != RRS_RUN) |-> test_strap_pins_o == '0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("output before sampling");

    property p_count;
        @(posedge sys_clk) disable iff (!held_n) (state_q == RRS_WAIT) |-> cnt_q < RRS_CNT_W'(SAMPLE_CYC);
    endproperty
    a_count: assert property (p_count) else $error("counter overran");

    property p_wait_entry;
        @(posedge sys_clk) disable iff (!held_n) $rose(released) |=> in_wait;
    endproperty
    a_wait_entry: assert property (p_wait_entry) else $error("self configuration not started");

    property p_active_rise;
        @(posedge sys_clk) disable iff (!held_n) $rose(config_active) |-> config_start;
    endproperty
    a_active_rise: assert property (p_active_rise) else $error("active without start pulse");

    property p_oe_only_run;
        @(posedge sys_clk) disable iff (!held_n) (test_strap_pins_oe != '0) |-> in_run;
    endproperty
    a_oe_only_run: assert property (p_oe_only_run) else $error("straps driven before sampling");

    property p_oe_whole;
        @(posedge sys_clk) disable iff (!held_n) (test_strap_pins_oe == '0) || (test_strap_pins_oe == '1);
    endproperty
    a_oe_whole: assert property (p_oe_whole) else $error("straps switched piecemeal");

    property p_single_sample;
        @(posedge sys_clk) disable iff (!held_n) in_sample |=> in_run;
    endproperty
    a_single_sample: assert property (p_single_sample) else $error("sampling not single");

    property p_drive_stays;
        @(posedge sys_clk) disable iff (!held_n) (in_run && $past(in_run))
            |-> test_strap_pins_oe == '1;
    endproperty
    a_drive_stays: assert property (p_drive_stays) else $error("strap drive dropped");

    property p_mode_hold;
        @(posedge sys_clk) disable iff (!held_n) (in_run && $past(in_run)) |-> $stable(test_mode_sel);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("test mode changed after sampling");

    property p_mode_refused;
        @(posedge sys_clk) disable iff (!held_n) (in_sample && !strap_agree) |=> test_mode_sel == '0;
    endproperty
    a_mode_refused: assert property (p_mode_refused) else $error("unsettled strap taken");

    property p_mode_capture;
        @(posedge sys_clk) disable iff (!held_n) (in_sample && strap_agree) |=> test_mode_sel == $past(s2_q);
    endproperty
    a_mode_capture: assert property (p_mode_capture) else $error("strap level not captured");

    property p_reserved_out;
        @(posedge sys_clk) disable iff (!held_n) (in_run && $past(in_run))
            |-> (test_strap_pins_o & ~TRIG_MASK) == ($past(test_out_data) & ~TRIG_MASK);
    endproperty
    a_reserved_out: assert property (p_reserved_out) else $error("reserved outputs wrong");

    property p_cnt_clear;
        @(posedge sys_clk) disable iff (!held_n) !in_wait |=> cnt_q == '0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter not cleared");

    c_release: cover property (@(posedge sys_clk) disable iff (!held_n) $rose(released));
    c_sample: cover property (@(posedge sys_clk) disable iff (!held_n) state_q == RRS_SAMPLE);
    c_mode: cover property (@(posedge sys_clk) disable iff (!held_n) test_mode_sel != '0);
    c_unstable: cover property (@(posedge sys_clk) disable iff (!held_n) in_sample && !strap_agree);
    c_abort: cover property (@(posedge sys_clk) in_wait ##1 !held_n);
endmodule

// *** sim/rrs_board_model.sv ***
// board model: reset source, scan reset and strap pin wiring
`timescale 1ns/1ps
module rrs_board_model
    import rrs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic hold_rst,
    input wire logic [RRS_STRAP_W-1:0] pull_up,
    input wire logic [RRS_STRAP_W-1:0] pin_o,
    input wire logic [RRS_STRAP_W-1:0] pin_oe,
    output logic power_on_reset_n,
    output logic scan_port_reset_n,
    output logic [RRS_STRAP_W-1:0] pin_lvl
);
    // release only once supplies are up
    always @(posedge sys_clk) power_on_reset_n <= ~hold_rst;
    assign scan_port_reset_n = 1'b0;
    // undriven pin goes to pull level
    assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & pull_up);
endmodule

// *** sim/tb_top.sv ***
// testbench for reset release and strap sampler
`timescale 1ns/1ps
module tb_top;
    import rrs_pkg::*;
    localparam int unsigned SC = 4;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hold_rst = 1'b1;
    logic trig = 1'b0;
    logic [7:0] pull_up = 8'h00;
    logic [7:0] tod = 8'h00;
    logic por_n, scan_n, cfg_start, cfg_act;
    logic [7:0] lvl, p_o, p_oe, mode;
    int err_total = 0;
    int samples_checked = 0;
    logic [15:0] rows [4] = '{16'h0000, 16'h0101, 16'h5A5A, 16'hFFFF};
    always #2.5 sys_clk = ~sys_clk;
    rrs_board_model rrs_board_model_i (.sys_clk(sys_clk), .hold_rst(hold_rst), .pull_up(pull_up), .pin_o(p_o),
        .pin_oe(p_oe), .power_on_reset_n(por_n), .scan_port_reset_n(scan_n), .pin_lvl(lvl));
    rrs_strap_sampler #(.SAMPLE_CYC(SC)) rrs_strap_sampler_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .power_on_reset_n(por_n), .scan_port_reset_n(scan_n), .test_strap_pins_i(lvl), .test_strap_pins_o(p_o),
        .test_strap_pins_oe(p_oe), .trigger_output_one(trig), .test_out_data(tod), .config_start(cfg_start),
        .config_active(cfg_act), .test_mode_sel(mode));
    task automatic cmp8(string nm, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic run_row(logic [15:0] row);
        int n;
        int pulses;
        n = 0;
        pulses = 0;
        pull_up = row[15:8];
        hold_rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        cmp8("oe_held", 8'h00, p_oe);
        cmp8("out_held", 8'h00, p_o | mode | {6'h00, cfg_act, cfg_start});
        hold_rst = 1'b0;
        while (p_oe !== 8'hFF && n < 50) begin
            @(negedge sys_clk);
            n++;
            pulses += (cfg_start === 1'b1);
        end
        cmp8("start_pulses", 8'h01, 8'(pulses));
        cmp8("lat_ok", 8'h01, {7'h00, n >= SC + 3 && n <= SC + 8});
        cmp8("mode", row[7:0], mode);
        cmp8("active", 8'h01, {7'h00, cfg_act});
        trig = row[8];
        tod = ~row[15:8];
        pull_up = ~row[15:8];
        repeat (2) @(negedge sys_clk);
        cmp8("pins", {tod[7:5], trig, tod[3:0]}, p_o);
        cmp8("mode_kept", row[7:0], mode);
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        arst_n = 1'b1;
        foreach (rows[i]) run_row(rows[i]);
        pull_up = 8'h10;
        hold_rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        hold_rst = 1'b0;
        repeat (5) @(negedge sys_clk);
        cmp8("abort_start", 8'h01, {7'h00, cfg_act});
        hold_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        cmp8("abort_oe", 8'h00, p_oe);
        cmp8("abort_mode", 8'h00, mode);
        cmp8("abort_act", 8'h00, {7'h00, cfg_act});
        pull_up = 8'h22;
        repeat (2) @(negedge sys_clk);
        hold_rst = 1'b0;
        repeat (7) @(negedge sys_clk);
        pull_up = 8'h33;
        repeat (4) @(negedge sys_clk);
        cmp8("unstable_oe", 8'hFF, p_oe);
        cmp8("unstable_mode", 8'h00, mode);
        run_row(16'h1010);
        summarize();
    end
    initial begin
        #20000;
        err_total++;
        summarize();
    end
endmodule
